// *** core/svmon_pkg.sv ***
// package of constants and types for the supply voltage monitor
package svmon_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 40000;
	localparam int unsigned SETTLE_TIME_US = 50;
	// least time, so round up
	localparam int unsigned SETTLE_CYCLES = (SETTLE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
	localparam logic [31:0] ADDR_MASK = 32'h0000_00FF;
	localparam int unsigned BIT_DET_EN = 0;
	localparam int unsigned BIT_IRQ_EN = 1;
	localparam int unsigned BIT_STICKY = 2;
	localparam int unsigned BIT_ABOVE = 3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic sticky_crossing_flag;
		logic detect_irq_enable;
		logic detector_enable;
	} svmon_ctrl_t;

	localparam svmon_ctrl_t CTRL_RESET = '{sticky_crossing_flag: 1'h0, detect_irq_enable: 1'h0,
		detector_enable: 1'h0};

	typedef enum logic [2:0] {
		ST_OFF    = 3'h1,
		ST_SETTLE = 3'h2,
		ST_ACTIVE = 3'h4
	} svmon_state_t;

endpackage

// *** core/svmon_top.sv ***
// supply voltage monitor: ahb-lite control register, comparator sync, flags and request
// Behaviour
// - ignore comparator until settle delay after enable
// - falling crossing clears level, sets sticky flag
// - rising crossing sets level and sticky flag
// - request on sticky 0-to-1 when enabled
// - handler reads sticky flag to identify source
// - level flag read-only, 1 when disabled
module svmon_top
	import svmon_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = svmon_pkg::SETTLE_CYCLES
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        cmp_above,
	output logic             detect_irq_req
);
	import svmon_pkg::*;

	// settle counter is 16 bits, so longer delays cannot be served
	if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
		$error("SETTLE_CYC out of range");
	end

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic        wr_pend_reg;
	logic        wr_pend_next;
	logic        resp_ready_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;
	logic        addr_hit;
	logic        accept;
	logic        wr_do;

	// hsize ignored: only whole words are used
	assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign addr_hit = ((haddr & ADDR_MASK) == CTRL_ADDR);
	assign wr_do = wr_pend_reg;

	// ------------------------------------------------------------
	// comparator synchroniser
	// ------------------------------------------------------------
	logic cmp_s1_reg;
	logic cmp_s2_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_s1_reg <= 1'h1;
			cmp_s2_reg <= 1'h1;
		end else begin
			cmp_s1_reg <= cmp_above;
			cmp_s2_reg <= cmp_s1_reg;
		end
	end

	// ------------------------------------------------------------
	// control, state and flags
	// ------------------------------------------------------------
	svmon_ctrl_t  ctrl_reg;
	svmon_ctrl_t  ctrl_next;
	svmon_state_t state_reg;
	svmon_state_t state_next;
	logic [15:0]  settle_cnt_reg;
	logic [15:0]  settle_cnt_next;
	logic         above_reg;
	logic         above_next;
	logic         irq_reg;
	logic         irq_next;
	logic         crossing;

	// only the second sync stage is compared, so each crossing counts once
	assign crossing = (state_reg == ST_ACTIVE) && (cmp_s2_reg != above_reg);

	always_comb begin
		ctrl_next = ctrl_reg;
		state_next = state_reg;
		settle_cnt_next = settle_cnt_reg;
		above_next = above_reg;
		if (wr_do) begin
			ctrl_next.detector_enable = hwdata[BIT_DET_EN];
			ctrl_next.detect_irq_enable = hwdata[BIT_IRQ_EN];
			// writing 1 leaves the flag alone
			if (!hwdata[BIT_STICKY]) begin
				ctrl_next.sticky_crossing_flag = 1'h0;
			end
		end
		// set wins over a clear in the same cycle
		if (crossing) begin
			ctrl_next.sticky_crossing_flag = 1'h1;
			above_next = cmp_s2_reg;
		end
		unique case (state_reg)
			ST_OFF: begin
				if (ctrl_reg.detector_enable) begin
					state_next = ST_SETTLE;
					settle_cnt_next = 16'h0001;
				end
			end
			ST_SETTLE: begin
				if (settle_cnt_reg >= 16'(SETTLE_CYC)) begin
					state_next = ST_ACTIVE;
				end else begin
					settle_cnt_next = settle_cnt_reg + 16'h0001;
				end
			end
			ST_ACTIVE: begin
			end
		endcase
		if (!ctrl_reg.detector_enable) begin
			state_next = ST_OFF;
			settle_cnt_next = 16'h0000;
		end
		// results while off or settling are invalid; level reads 1
		if (state_next != ST_ACTIVE) begin
			above_next = 1'h1;
		end
		irq_next = ctrl_reg.detect_irq_enable && ctrl_next.sticky_crossing_flag
			&& !ctrl_reg.sticky_crossing_flag;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= CTRL_RESET;
			state_reg <= ST_OFF;
			settle_cnt_reg <= 16'h0000;
			above_reg <= 1'h1;
			irq_reg <= 1'h0;
		end else begin
			ctrl_reg <= ctrl_next;
			state_reg <= state_next;
			settle_cnt_reg <= settle_cnt_next;
			above_reg <= above_next;
			irq_reg <= irq_next;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// read data built from next values so a read right after a write sees it
	always_comb begin
		wr_pend_next = accept && hwrite && addr_hit;
		hrdata_next = hrdata_reg;
		if (accept && !hwrite) begin
			hrdata_next = 32'h0000_0000;
			if (addr_hit) begin
				hrdata_next[BIT_DET_EN] = ctrl_next.detector_enable;
				hrdata_next[BIT_IRQ_EN] = ctrl_next.detect_irq_enable;
				hrdata_next[BIT_STICKY] = ctrl_next.sticky_crossing_flag;
				hrdata_next[BIT_ABOVE] = above_next;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'h0;
			hrdata_reg <= 32'h0000_0000;
			resp_ready_reg <= 1'h1;
		end else begin
			wr_pend_reg <= wr_pend_next;
			hrdata_reg <= hrdata_next;
			resp_ready_reg <= 1'h1;
		end
	end

	assign hrdata = hrdata_reg;
	// zero wait states; ready stays high through reset too
	assign hreadyout = resp_ready_reg;
	assign hresp = HRESP_OKAY;
	assign detect_irq_req = irq_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// own age count since enable, saturating; keeps the settle checks apart from the design counter
	logic [16:0] chk_age_reg;
	logic [16:0] chk_age_next;

	always_comb begin
		chk_age_next = chk_age_reg;
		if (!ctrl_reg.detector_enable) begin
			chk_age_next = 17'h0_0000;
		end else if (chk_age_reg != 17'h1_FFFF) begin
			chk_age_next = chk_age_reg + 17'h0_0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chk_age_reg <= 17'h0_0000;
		end else begin
			chk_age_reg <= chk_age_next;
		end
	end

	property p_settle_quiet;
		(ctrl_reg.detector_enable && chk_age_reg != 17'h0_0000 && chk_age_reg <= 17'(SETTLE_CYC))
			|-> (state_reg != ST_ACTIVE && above_reg && !irq_reg);
	endproperty
	a_settle_quiet: assert property (p_settle_quiet) else $error("flags moved during settle");

	property p_settle_end;
		(ctrl_reg.detector_enable && chk_age_reg == 17'(SETTLE_CYC) + 17'h0_0001) |-> state_reg == ST_ACTIVE;
	endproperty
	a_settle_end: assert property (p_settle_end) else $error("settle did not end on time");

	property p_fall;
		(state_reg == ST_ACTIVE && above_reg && !cmp_s2_reg && ctrl_reg.detector_enable)
			|=> (!above_reg && ctrl_reg.sticky_crossing_flag);
	endproperty
	a_fall: assert property (p_fall) else $error("falling crossing not flagged");

	property p_rise;
		(state_reg == ST_ACTIVE && !above_reg && cmp_s2_reg) |=> (above_reg && ctrl_reg.sticky_crossing_flag);
	endproperty
	a_rise: assert property (p_rise) else $error("rising crossing not flagged");

	property p_irq;
		detect_irq_req == ($rose(ctrl_reg.sticky_crossing_flag) && $past(ctrl_reg.detect_irq_enable));
	endproperty
	a_irq: assert property (p_irq) else $error("request not tied to sticky rise");

	property p_clear_by_sw;
		$fell(ctrl_reg.sticky_crossing_flag) |-> $past(wr_pend_reg && !hwdata[BIT_STICKY]);
	endproperty
	a_clear_by_sw: assert property (p_clear_by_sw) else $error("sticky cleared without write");

	property p_read_sticky;
		(accept && !hwrite && addr_hit && !wr_pend_reg && !crossing)
			|=> hrdata[BIT_STICKY] == ctrl_reg.sticky_crossing_flag;
	endproperty
	a_read_sticky: assert property (p_read_sticky) else $error("read data lost sticky");

	property p_off_above;
		!ctrl_reg.detector_enable |=> above_reg;
	endproperty
	a_off_above: assert property (p_off_above) else $error("level low while off");

	property p_sync_change;
		(state_reg == ST_ACTIVE && $changed(above_reg)) |-> above_reg == $past(cmp_s2_reg);
	endproperty
	a_sync_change: assert property (p_sync_change) else $error("level not from sync stage");

	c_fall_irq: cover property (ctrl_reg.detect_irq_enable && $fell(above_reg) && detect_irq_req);
	c_rise: cover property ($rose(above_reg) && state_reg == ST_ACTIVE);
	c_clear: cover property ($fell(ctrl_reg.sticky_crossing_flag));

endmodule // svmon_top

// *** dv/svmon_cmp_model.sv ***
// behavioural model of the analog supply comparator
module svmon_cmp_model (
	input  wire logic       supply_ok,
	input  wire logic [7:0] lag_ns,
	output logic            cmp_above
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// comparator output
	// ------------------------------------------------------------
	// hysteresis lives in the analog part, so one change per crossing
	// lag puts edges off the clock grid, so the sync path is exercised
	initial begin
		cmp_above = 1'b1;
		forever begin
			@(supply_ok);
			cmp_above <= #(lag_ns) supply_ok;
		end
	end
endmodule // svmon_cmp_model

// *** dv/tb_top.sv ***
// self-checking testbench for the supply voltage monitor
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        hclk      = 1'b0;
	logic        hresetn   = 1'b0;
	logic        hsel      = 1'b1;
	logic [31:0] haddr     = 32'h0;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic [31:0] hwdata    = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        cmp_above;
	logic        detect_irq_req;
	logic        supply_ok = 1'b1;
	logic [7:0]  lag_ns    = 8'h07;
	logic [31:0] rd;
	logic        rsp;
	int          n_errors  = 0;
	int          checked   = 0;
	int          n_irq     = 0;

	always #20 hclk = ~hclk;
	always @(posedge hclk) begin
		if (detect_irq_req === 1'b1) begin
			n_irq <= n_irq + 1;
		end
	end

	// short settle keeps the run brief
	svmon_top #(.SETTLE_CYC(20)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cmp_above(cmp_above), .detect_irq_req(detect_irq_req)
	);
	svmon_cmp_model u_cmp (.supply_ok(supply_ok), .lag_ns(lag_ns), .cmp_above(cmp_above));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
		haddr  <= a;
		hwrite <= w;
		htrans <= svmon_pkg::HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		rsp = hresp;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		check(rd, e);
		check(32'(rsp), 32'(svmon_pkg::HRESP_OKAY));
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic close_out;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rdchk(32'h0, 32'h0000_0008);
		rdchk(32'h10, 32'h0);
	endtask
	task automatic t_settle;
		xfer(32'h0, 1'b1, 32'h0000_0003);
		supply_ok <= 1'b0;
		rdchk(32'h0, 32'h0000_000B);
		check(n_irq, 0);
		idle(5);
		rdchk(32'h0, 32'h0000_000B);
		idle(35);
		rdchk(32'h0, 32'h0000_0007);
		check(n_irq, 1);
	endtask
	task automatic t_clear;
		xfer(32'h0, 1'b1, 32'h0000_0003);
		rdchk(32'h0, 32'h0000_0003);
		xfer(32'h0, 1'b1, 32'h0000_0007);
		rdchk(32'h0, 32'h0000_0003);
	endtask
	task automatic t_rise;
		lag_ns    <= 8'h21;
		supply_ok <= 1'b1;
		idle(10);
		rdchk(32'h0, 32'h0000_000F);
		check(n_irq, 2);
		supply_ok <= 1'b0;
		idle(10);
		rdchk(32'h0, 32'h0000_0007);
		check(n_irq, 2);
	endtask
	task automatic t_mask;
		xfer(32'h0, 1'b1, 32'h0000_0001);
		supply_ok <= 1'b1;
		idle(10);
		rdchk(32'h0, 32'h0000_000D);
		check(n_irq, 2);
	endtask
	task automatic t_disable;
		xfer(32'h0, 1'b1, 32'h0000_0005);
		rdchk(32'h0, 32'h0000_000D);
		supply_ok <= 1'b0;
		idle(10);
		xfer(32'h0, 1'b1, 32'h0000_0004);
		rdchk(32'h0, 32'h0000_000C);
		check(n_irq, 2);
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		idle(10);
		hresetn <= 1'b1;
		t_reset();
		t_settle();
		t_clear();
		t_rise();
		t_mask();
		t_disable();
		close_out();
	end
	// whole run needs about 126 cycles
	initial begin
		idle(3000);
		n_errors++;
		close_out();
	end
endmodule // tb_top
